/* File: src/wpm_supervisor.sv */
// Supervisor: timer rate control, power-on reset, power-fail interrupt, watchdog
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps

module wpm_supervisor
   import wpm_pkg::*;
#(
   parameter int POR_CLOCKS = 65536,      // Oscillator clocks before reset release
   parameter int WD_TO0     = 131072,     // 2^17
   parameter int WD_TO1     = 1048576,    // 2^20
   parameter int WD_TO2     = 8388608,    // 2^23
   parameter int WD_TO3     = 67108864    // 2^26
) (
   input  wire logic        mclk,             // Crystal clock, 20 MHz
   input  wire logic        sys_rst,          // Synchronous reset, active high
   input  wire logic [11:0] s_axi_awaddr,     // Write address
   input  wire logic        s_axi_awvalid,    // Write address valid
   output      logic        s_axi_awready,    // Write address ready
   input  wire logic [31:0] s_axi_wdata,      // Write data
   input  wire logic [3:0]  s_axi_wstrb,      // Write strobes
   input  wire logic        s_axi_wvalid,     // Write data valid
   output      logic        s_axi_wready,     // Write data ready
   output      logic [1:0]  s_axi_bresp,      // Write response
   output      logic        s_axi_bvalid,     // Write response valid
   input  wire logic        s_axi_bready,     // Write response ready
   input  wire logic [11:0] s_axi_araddr,     // Read address
   input  wire logic        s_axi_arvalid,    // Read address valid
   output      logic        s_axi_arready,    // Read address ready
   output      logic [31:0] s_axi_rdata,      // Read data
   output      logic [1:0]  s_axi_rresp,      // Read response
   output      logic        s_axi_rvalid,     // Read data valid
   input  wire logic        s_axi_rready,     // Read data ready
   input  wire logic        vcc_below_rst,    // Monitor: below reset_supply_threshold
   input  wire logic        vcc_below_warn,   // Monitor: below warning_supply_threshold
   input  wire logic        ta_unlock,        // Timed-access open for this cycle
   input  wire logic        irq_ack,          // Core takes the offered interrupt
   input  wire logic        pfi_done,         // Core returns from power-fail service
   input  wire logic        ext_irq_req,      // Lower-priority interrupt request
   input  wire logic [15:0] ext_irq_vec,      // Vector of that request
   output      logic        osc_en,           // Crystal oscillator enable
   output      logic        cpu_rst,          // Reset to the processor core
   output      logic [2:0]  tmr_tick,         // Count enables for timers 2..0
   output      logic        baud_tick,        // Serial baud generator enable
   output      logic        irq_req,          // Interrupt request to core
   output      logic [15:0] irq_vec,          // Vector of the winning request
   output      logic        cpu_wake          // Wake from power-saving mode
);

   // ************************************************************
   // Declarations
   // ************************************************************
   localparam int PW = $clog2(POR_CLOCKS + 1);

   wpm_por_t    por_state, next_por_state;
   logic [PW-1:0] por_cnt;
   logic [7:0]  clk_ctl, rd_byte;
   wpm_wdctl_t  wd_ctl;
   logic        por_active, wdi_en, pf_in_service;
   logic [26:0] wd_cnt, wd_int_to, wd_rst_to;
   logic        wd_hit_int, wd_hit_rst, wd_restart, wd_fire;
   logic [2:0]  wd_rst_len, spd_sel, next_tick;
   logic [3:0]  div_slow, div_fast;
   logic        slow_en, fast_en, rd_take, rd_hit;
   logic        wr_take, wr_lane0, wr_clkctl, wr_wdctl, wr_extie, wr_hit;
   logic        pfi_pend, wdi_pend, next_irq_req;
   logic [15:0] next_irq_vec;
   logic [9:0]  int_age;

   // ************************************************************
   // Power-on and brown-out reset sequencer
   // ************************************************************
   // Any dip below the reset threshold restarts the whole count
   always_comb begin
      next_por_state = por_state;
      case (por_state)
         PS_HOLD:  if (!vcc_below_rst) next_por_state = PS_COUNT;
         PS_COUNT: if (por_cnt == PW'(POR_CLOCKS - 1)) next_por_state = PS_RUN;
         PS_RUN:   next_por_state = PS_RUN;
         default:  next_por_state = PS_HOLD;
      endcase
      if (vcc_below_rst) begin
         next_por_state = PS_HOLD;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         por_state <= PS_HOLD;
         por_cnt   <= '0;
      end else begin
         por_state <= next_por_state;
         por_cnt   <= (por_state == PS_COUNT) ? por_cnt + 1'b1 : '0;
      end
   end

   assign por_active = (por_state != PS_RUN);

   // Core reset covers the power sequence and a short watchdog pulse
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         osc_en  <= 1'b0;
         cpu_rst <= 1'b1;
      end else begin
         osc_en  <= (next_por_state != PS_HOLD);
         cpu_rst <= (next_por_state != PS_RUN) || wd_fire || (wd_rst_len != 3'h0);
      end
   end

   // ************************************************************
   // Timer and baud rate dividers
   // ************************************************************
   // Both dividers run off every crystal clock; selection is per timer
   always_ff @(posedge mclk) begin
      if (sys_rst || por_active) begin
         div_slow <= 4'h0;
         div_fast <= 4'h0;
      end else begin
         div_slow <= slow_en ? 4'h0 : div_slow + 4'h1;
         div_fast <= fast_en ? 4'h0 : div_fast + 4'h1;
      end
   end

   assign slow_en = (div_slow == DIV_SLOW - 4'h1);
   assign fast_en = (div_fast == DIV_FAST - 4'h1);
   assign spd_sel = {clk_ctl[SPD_T2_BIT], clk_ctl[SPD_T1_BIT], clk_ctl[SPD_T0_BIT]};

   // Each timer chooses its own rate independently
   generate
      for (genvar t = 0; t < 3; t++) begin : g_tick
         assign next_tick[t] = spd_sel[t] ? fast_en : slow_en;
      end
   endgenerate

   // Baud generator stays at the twelve-clock rate
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         tmr_tick  <= 3'h0;
         baud_tick <= 1'b0;
      end else begin
         tmr_tick  <= next_tick;
         baud_tick <= slow_en;
      end
   end

   // ************************************************************
   // Watchdog counter
   // ************************************************************
   // Widths are fixed at 27 bits so the longest reset timeout fits
   always_comb begin
      case ({clk_ctl[TSEL_HI_BIT], clk_ctl[TSEL_LO_BIT]})
         2'b00:   wd_int_to = 27'(WD_TO0);
         2'b01:   wd_int_to = 27'(WD_TO1);
         2'b10:   wd_int_to = 27'(WD_TO2);
         2'b11:   wd_int_to = 27'(WD_TO3);
         default: wd_int_to = 27'(WD_TO0);
      endcase
   end

   assign wd_rst_to  = wd_int_to + WD_PRE_RESET;
   assign wd_hit_int = (wd_cnt == wd_int_to - 27'h1);
   assign wd_hit_rst = (wd_cnt == wd_rst_to - 27'h1);
   assign wd_restart = wr_wdctl && ta_unlock && s_axi_wdata[WD_RSTRT_BIT];
   assign wd_fire    = wd_hit_rst && wd_ctl.wdr_en && !wd_restart;

   // Counts every crystal clock; wraps at the reset timeout as a time base
   always_ff @(posedge mclk) begin
      if (sys_rst || por_active || wd_restart || wd_hit_rst) begin
         wd_cnt <= 27'h0;
      end else begin
         wd_cnt <= wd_cnt + 27'h1;
      end
   end

   // Stretch a watchdog reset so the core sees a clean pulse
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         wd_rst_len <= 3'h0;
      end else if (wd_fire) begin
         wd_rst_len <= WD_RST_CYCLES - 3'h1;
      end else if (wd_rst_len != 3'h0) begin
         wd_rst_len <= wd_rst_len - 3'h1;
      end
   end

   // ************************************************************
   // AXI4-Lite slave
   // ************************************************************
   // Only byte lane 0 carries register data; 32-bit words, upper bits read zero
   assign wr_take   = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   assign wr_lane0  = wr_take && s_axi_wstrb[0];
   assign wr_clkctl = wr_lane0 && (s_axi_awaddr == CLKCTL_ADDR);
   assign wr_wdctl  = wr_lane0 && (s_axi_awaddr == WDCTL_ADDR);
   assign wr_extie  = wr_lane0 && (s_axi_awaddr == EXTIE_ADDR);
   assign wr_hit    = (s_axi_awaddr == CLKCTL_ADDR) || (s_axi_awaddr == WDCTL_ADDR) ||
                      (s_axi_awaddr == EXTIE_ADDR) || (s_axi_awaddr == SVCSTAT_ADDR);
   assign rd_take   = s_axi_arvalid && s_axi_arready;
   assign rd_hit    = (s_axi_araddr == CLKCTL_ADDR) || (s_axi_araddr == WDCTL_ADDR) ||
                      (s_axi_araddr == EXTIE_ADDR) || (s_axi_araddr == SVCSTAT_ADDR);

   // Read mux; the restart bit always reads zero
   always_comb begin
      rd_byte = 8'h00;
      case (s_axi_araddr)
         CLKCTL_ADDR:  rd_byte = clk_ctl;
         WDCTL_ADDR:   rd_byte = {2'b00, wd_ctl, 1'b0};
         EXTIE_ADDR:   rd_byte = 8'(wdi_en) << WDI_EN_BIT;
         SVCSTAT_ADDR: rd_byte = 8'(pf_in_service) << PIP_BIT;
         default:      rd_byte = 8'h00;
      endcase
   end

   // Address and data are taken together, one write outstanding
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
         if (wr_take) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // One read outstanding; unmapped reads return zero with an error
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h0, rd_byte};
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Control registers
   // ************************************************************
   // Power sequence clears controls; sticky flags survive for software
   always_ff @(posedge mclk) begin
      if (sys_rst || por_active) begin
         clk_ctl       <= CLKCTL_RST;
         wd_ctl.pfi_en <= 1'b0;
         wd_ctl.wdr_en <= 1'b0;
         wdi_en        <= 1'b0;
      end else begin
         if (wr_clkctl) begin
            clk_ctl <= {s_axi_wdata[7:3], 3'b000};
         end
         if (wr_wdctl) begin
            wd_ctl.pfi_en <= s_axi_wdata[PFI_EN_BIT];
         end
         if (wr_wdctl && ta_unlock) begin
            wd_ctl.wdr_en <= s_axi_wdata[WDR_EN_BIT];
         end
         if (wr_extie) begin
            wdi_en <= s_axi_wdata[WDI_EN_BIT];
         end
      end
      // Sticky flags: hardware set beats a same-cycle software clear
      if (sys_rst) begin
         wd_ctl.pfi_flag <= 1'b0;
         wd_ctl.wdi_flag <= 1'b0;
         wd_ctl.wdr_flag <= 1'b0;
      end else begin
         if (vcc_below_warn) begin
            wd_ctl.pfi_flag <= 1'b1;
         end else if (wr_wdctl && !s_axi_wdata[PFI_FLAG_BIT]) begin
            wd_ctl.pfi_flag <= 1'b0;
         end
         if (wd_hit_int && !wd_restart && !por_active) begin
            wd_ctl.wdi_flag <= 1'b1;
         end else if (wr_wdctl && !s_axi_wdata[WDI_FLAG_BIT]) begin
            wd_ctl.wdi_flag <= 1'b0;
         end
         if (wd_fire && !por_active) begin
            wd_ctl.wdr_flag <= 1'b1;
         end else if (wr_wdctl && !s_axi_wdata[WDR_FLAG_BIT]) begin
            wd_ctl.wdr_flag <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Interrupt arbitration
   // ************************************************************
   // Power-fail is held off while its own service runs
   assign pfi_pend = wd_ctl.pfi_en && wd_ctl.pfi_flag && !pf_in_service;
   assign wdi_pend = wdi_en && wd_ctl.wdi_flag;
   assign next_irq_req = !por_active && (pfi_pend || wdi_pend || ext_irq_req);
   assign next_irq_vec = pfi_pend ? PFI_VECTOR :
                         wdi_pend ? WDI_VECTOR : ext_irq_vec;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         irq_req       <= 1'b0;
         irq_vec       <= 16'h0;
         cpu_wake      <= 1'b0;
         pf_in_service <= 1'b0;
      end else begin
         irq_req  <= next_irq_req;
         irq_vec  <= next_irq_vec;
         cpu_wake <= wdi_pend && !por_active;
         if (por_active) begin
            pf_in_service <= 1'b0;
         end else if (irq_ack && irq_req && irq_vec == PFI_VECTOR) begin
            pf_in_service <= 1'b1;
         end else if (pfi_done) begin
            pf_in_service <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   // Cycles since the interrupt timeout, for the pre-reset gap check
   always_ff @(posedge mclk) begin
      if (sys_rst || wd_restart || (wd_hit_int && !por_active)) begin
         int_age <= 10'h0;
      end else if (int_age != 10'h3ff) begin
         int_age <= int_age + 10'h1;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   chk_slow_gap: assert property (
      tmr_tick[0] && !clk_ctl[SPD_T0_BIT] |=> (!tmr_tick[0] || $past(clk_ctl[SPD_T0_BIT])) [*8])
      else $error("slow timer tick came too soon");
   chk_fast_period: assert property (
      (tmr_tick[2] && clk_ctl[SPD_T2_BIT]) ##1 clk_ctl[SPD_T2_BIT] [*3] |=> tmr_tick[2])
      else $error("fast timer 2 tick missing after four clocks");
   chk_brownout_hold: assert property (
      vcc_below_rst |=> cpu_rst && por_state == PS_HOLD)
      else $error("reset not held below threshold");
   chk_por_delay: assert property (
      por_state == PS_HOLD && !vcc_below_rst |=> (osc_en && cpu_rst) [*8])
      else $error("reset released too early after power-up");
   chk_pf_flag_set: assert property (
      vcc_below_warn |=> wd_ctl.pfi_flag)
      else $error("power-fail flag not set by warning");
   chk_pf_priority: assert property (
      pfi_pend && !por_active && (ext_irq_req || wdi_pend) |=> irq_req && irq_vec == PFI_VECTOR)
      else $error("power-fail did not win arbitration");
   chk_wd_pre_gap: assert property (
      $rose(wd_ctl.wdr_flag) |-> int_age == 10'd512 && cpu_rst)
      else $error("watchdog reset not 512 clocks after interrupt");
   chk_protect_en: assert property (
      wr_wdctl && !ta_unlock && !por_active |=> $stable(wd_ctl.wdr_en))
      else $error("reset enable changed without unlock");
   chk_restart_zero: assert property (
      wd_restart |=> wd_cnt == 27'h0 ##1 wd_cnt == 27'h1)
      else $error("watchdog restart did not return to zero");
   chk_pip_set: assert property (
      irq_ack && irq_req && irq_vec == PFI_VECTOR && !por_active
      |=> pf_in_service ##1 (!irq_req || irq_vec != PFI_VECTOR))
      else $error("power-fail service status not set");

endmodule

/* File: src/wpm_pkg.sv */
// Package: register map, field positions, reset values and counts of the supervisor
package wpm_pkg;

   // ************************************************************
   // Register indices (printed offsets) and byte addresses
   // ************************************************************
   localparam logic [7:0]  CLKCTL_IDX  = 8'h8e;
   localparam logic [7:0]  WDCTL_IDX   = 8'hd8;
   localparam logic [7:0]  EXTIE_IDX   = 8'he8;
   localparam logic [7:0]  SVCSTAT_IDX = 8'hf0;
   localparam logic [11:0] CLKCTL_ADDR  = {2'b00, CLKCTL_IDX, 2'b00};
   localparam logic [11:0] WDCTL_ADDR   = {2'b00, WDCTL_IDX, 2'b00};
   localparam logic [11:0] EXTIE_ADDR   = {2'b00, EXTIE_IDX, 2'b00};
   localparam logic [11:0] SVCSTAT_ADDR = {2'b00, SVCSTAT_IDX, 2'b00};

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int TSEL_HI_BIT  = 7;  // timeout_select_high
   localparam int TSEL_LO_BIT  = 6;  // timeout_select_low
   localparam int SPD_T2_BIT   = 5;
   localparam int SPD_T1_BIT   = 4;
   localparam int SPD_T0_BIT   = 3;
   localparam int PFI_EN_BIT   = 5;
   localparam int PFI_FLAG_BIT = 4;
   localparam int WDI_FLAG_BIT = 3;
   localparam int WDR_FLAG_BIT = 2;
   localparam int WDR_EN_BIT   = 1;
   localparam int WD_RSTRT_BIT = 0;
   localparam int WDI_EN_BIT   = 4;  // In extended_interrupt_enable
   localparam int PIP_BIT      = 7;  // power_fail_in_service

   // ************************************************************
   // Reset values, counts and vectors
   // ************************************************************
   localparam logic [7:0]  CLKCTL_RST     = 8'h00;
   localparam logic [3:0]  DIV_SLOW       = 4'hc;   // 12 clocks per timer cycle
   localparam logic [3:0]  DIV_FAST       = 4'h4;   // 4 clocks per timer cycle
   localparam logic [26:0] WD_PRE_RESET   = 27'h0000200;  // 512 clocks
   localparam logic [2:0]  WD_RST_CYCLES  = 3'h4;
   localparam logic [15:0] PFI_VECTOR     = 16'h0033;
   localparam logic [15:0] WDI_VECTOR     = 16'h006b;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   // Watchdog and power-fail control bits held by the block
   typedef struct packed {
      logic pfi_en;
      logic pfi_flag;
      logic wdi_flag;
      logic wdr_flag;
      logic wdr_en;
   } wpm_wdctl_t;

   typedef enum logic [1:0] {PS_HOLD, PS_COUNT, PS_RUN} wpm_por_t;

endpackage

/* File: tb/wpm_core_model.sv */
// Core model: takes offered interrupts and leaves power-fail service later
`timescale 1ns/1ps
module wpm_core_model
   import wpm_pkg::*;
#(
   parameter int ACK_DLY = 6,  // Cycles before taking a request
   parameter int SVC_LEN = 40  // Cycles spent in power-fail service
) (
   input  wire logic        mclk,     // Crystal clock
   input  wire logic        sys_rst,  // Reset
   input  wire logic        irq_req,  // Offered request
   input  wire logic [15:0] irq_vec,  // Offered vector
   output      logic        irq_ack,  // Take pulse
   output      logic        pfi_done  // Leave service pulse
);
   int wait_n;
   int svc_n;
   // Slow take, so a late higher request must replace the first offer
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         wait_n   <= 0;
         svc_n    <= 0;
         irq_ack  <= 1'b0;
         pfi_done <= 1'b0;
      end else begin
         wait_n   <= (irq_req && !irq_ack && wait_n < ACK_DLY) ? wait_n + 1 : 0;
         irq_ack  <= irq_req && !irq_ack && wait_n == ACK_DLY;
         pfi_done <= svc_n == 1;
         if (irq_ack && irq_vec == PFI_VECTOR) svc_n <= SVC_LEN;
         else if (svc_n > 0) svc_n <= svc_n - 1;
      end
   end
endmodule

/* File: tb/watchdog_power_monitor_timer_rate_tb_top.sv */
// Testbench: register map, timer rates, power sequencing, power-fail, watchdog
`timescale 1ns/1ps
module watchdog_power_monitor_timer_rate_tb_top;
   import wpm_pkg::*;
   typedef struct packed {logic w; logic [11:0] a; logic [7:0] wd, rd; logic [1:0] rs;} wpm_row_t;
   localparam int POR_N = 64;
   localparam int TO0   = 1024;
   logic        mclk = 0, sys_rst = 1, vcc_below_rst = 1, vcc_below_warn = 0;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0, ta_unlock = 0, ext_irq_req = 0;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [15:0] ext_irq_vec = 16'h0003, irq_vec;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        irq_ack, pfi_done, osc_en, cpu_rst, baud_tick, irq_req, cpu_wake;
   logic [2:0]  tmr_tick;
   int          fail_count = 0;
   int          check_count = 0;
   int          gaps [4] = '{4, 12, 4, 12};
   int          tos [4] = '{TO0, 2048, 4096, 8192};
   // Ordinary register cases: write, address, data, read-back, response
   wpm_row_t rows [6] = '{'{0, CLKCTL_ADDR, 8'h00, CLKCTL_RST, RESP_OKAY},
      '{1, CLKCTL_ADDR, 8'h2f, 8'h28, RESP_OKAY}, '{1, SVCSTAT_ADDR, 8'hff, 8'h00, RESP_OKAY},
      '{1, EXTIE_ADDR, 8'h10, 8'h10, RESP_OKAY}, '{1, WDCTL_ADDR, 8'h23, 8'h20, RESP_OKAY},
      '{1, 12'h004, 8'h55, 8'h00, RESP_SLVERR}};
   wpm_supervisor #(.POR_CLOCKS(POR_N), .WD_TO0(TO0), .WD_TO1(2048), .WD_TO2(4096),
      .WD_TO3(8192)) dut (.mclk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .vcc_below_rst, .vcc_below_warn, .ta_unlock,
      .irq_ack, .pfi_done, .ext_irq_req, .ext_irq_vec, .osc_en, .cpu_rst, .tmr_tick,
      .baud_tick, .irq_req, .irq_vec, .cpu_wake);
   wpm_core_model core (.mclk, .sys_rst, .irq_req, .irq_vec, .irq_ack, .pfi_done);
   always #25 mclk = ~mclk;
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Count edges until a watched signal is high; a spent bound ends the run
   task automatic edges_until(input int idx, input int lim, output int n);
      logic [6:0] w;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
         w = {~cpu_rst, cpu_rst, cpu_wake, baud_tick, tmr_tick};
      end while (w[idx] !== 1'b1 && n <= lim);
      check("bounded wait", n <= lim, 1);
      if (n > lim) end_sim();
   endtask
   task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic ul,
                         output logic [1:0] r);
      int n;
      n = 0;
      @(posedge mclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      ta_unlock     <= ul;
      do begin
         @(posedge mclk);
         n++;
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_awready === 1'b1) ta_unlock <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 40);
      if (n >= 40) check("write answer", 0, 1);
      if (n >= 40) end_sim();
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge mclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 40);
      if (n >= 40) check("read answer", 0, 1);
      if (n >= 40) end_sim();
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      int          n;
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (6) @(posedge mclk);
      // Supply still low: core held, oscillator off
      check("core reset", cpu_rst, 1);
      check("oscillator", osc_en, 0);
      vcc_below_rst <= 1'b0;
      edges_until(6, POR_N + 8, n);
      check("release delay", n >= POR_N && n <= POR_N + 3, 1);
      check("oscillator", osc_en, 1);
      foreach (rows[i]) begin
         if (rows[i].w) axi_wr(rows[i].a, rows[i].wd, 1'b0, r);
         if (rows[i].w) check("write resp", r, rows[i].rs);
         axi_rd(rows[i].a, d, r);
         check("read data", d, rows[i].rd);
         check("read resp", r, rows[i].rs);
      end
      // Timers 2 and 0 fast, timer 1 and baud at the default rate
      foreach (gaps[i]) begin
         edges_until(i, 30, n);
         edges_until(i, 30, n);
         check("tick period", n, gaps[i]);
      end
      // Power-fail warning racing a lower source that was offered first
      ext_irq_req    <= 1'b1;
      vcc_below_warn <= 1'b1;
      repeat (4) @(posedge mclk);
      check("pf request", irq_req, 1);
      check("pf vector", irq_vec, PFI_VECTOR);
      repeat (8) @(posedge mclk);
      axi_rd(SVCSTAT_ADDR, d, r);
      check("in service", d, 32'h80);
      vcc_below_warn <= 1'b0;
      ext_irq_req    <= 1'b0;
      axi_rd(WDCTL_ADDR, d, r);
      check("pf flag kept", d, 32'h30);
      axi_wr(WDCTL_ADDR, 8'h20, 1'b0, r);
      axi_rd(WDCTL_ADDR, d, r);
      check("pf flag cleared", d, 32'h20);
      // Restart and arm at timeout select 0; restart again midway so only the second one counts
      axi_wr(WDCTL_ADDR, 8'h23, 1'b1, r);
      repeat (600) @(posedge mclk);
      axi_wr(WDCTL_ADDR, 8'h23, 1'b1, r);
      edges_until(4, TO0 + 8, n);
      check("interrupt timeout", n >= TO0 - 2 && n <= TO0 + 1, 1);
      edges_until(5, 600, n);
      check("reset after interrupt", n >= 511 && n <= 512, 1);
      edges_until(6, 10, n);
      check("reset width", n, 4);
      axi_rd(WDCTL_ADDR, d, r);
      check("watchdog flags", d, 32'h2e);
      axi_rd(SVCSTAT_ADDR, d, r);
      check("service left", d, 32'h0);
      // Remaining timeout selects, reset disarmed; the restart write also clears the flags
      for (int s = 1; s < 4; s++) begin
         axi_wr(CLKCTL_ADDR, {2'(s), 6'h28}, 1'b0, r);
         axi_wr(WDCTL_ADDR, 8'h21, 1'b1, r);
         edges_until(4, tos[s] + 8, n);
         check("select timeout", n >= tos[s] - 2 && n <= tos[s] + 1, 1);
      end
      // Supply drop holds reset without software and restores the slow rate
      vcc_below_rst <= 1'b1;
      edges_until(5, 4, n);
      repeat (20) @(posedge mclk);
      check("brown-out hold", cpu_rst, 1);
      axi_rd(CLKCTL_ADDR, d, r);
      check("rate after brown-out", d, CLKCTL_RST);
      end_sim();
   end
endmodule
